// *** design/drs_map.vh ***
`ifndef DRS_MAP_VH
`define DRS_MAP_VH

// =====================================================================
// register indices (byte address = index * 4)
// =====================================================================
`define DRS_IDX_CTRL        7'h40
`define DRS_IDX_VTIMER      7'h41
`define DRS_IDX_STATUS      7'h42
`define DRS_IDX_BUFCFG_A    7'h43
`define DRS_IDX_BUFCFG_B    7'h44
`define DRS_IDX_BUFSTAT     7'h45
`define DRS_IDX_LSB         2
`define DRS_IDX_MSB         8

// =====================================================================
// control register fields
// =====================================================================
`define DRS_CTRL_MODE_LSB   0
`define DRS_CTRL_MODE_MSB   1
`define DRS_CTRL_MANSEL     2
`define DRS_CTRL_PINSEL     3
`define DRS_CTRL_PRIO0_LSB  4
`define DRS_CTRL_PRIO0_MSB  6
`define DRS_CTRL_PRIO1_LSB  8
`define DRS_CTRL_PRIO1_MSB  10
`define DRS_CTRL_WMASK      32'h0000_077f
`define DRS_CTRL_RESET      32'h0000_0000
`define DRS_VTIMER_WMASK    32'h0000_ffff
`define DRS_VTIMER_RESET    32'h0000_0100
`define DRS_BUFCFG_WMASK    32'h0000_00ff
`define DRS_BUFCFG_RESET    32'h0000_0000

// =====================================================================
// selection modes
// =====================================================================
`define DRS_MODE_REVERT     2'h0
`define DRS_MODE_NONREVERT  2'h1
`define DRS_MODE_MAN_FALL   2'h2
`define DRS_MODE_MAN_HOLD   2'h3

// =====================================================================
// priority and buffer type codes
// =====================================================================
`define DRS_PRIO_W          3
`define DRS_PRIO_NEVER      3'h0
`define DRS_VTIMER_W        16
`define DRS_CODE_W          6
`define DRS_CODE_00         6'h00
`define DRS_CODE_01         6'h01
`define DRS_CODE_02         6'h02
`define DRS_CODE_03         6'h03
`define DRS_CODE_04         6'h04
`define DRS_CODE_05         6'h05
`define DRS_CODE_08         6'h08
`define DRS_CODE_0C         6'h0c
`define DRS_CODE_18         6'h18
`define DRS_CODE_28         6'h28
`define DRS_CODE_38         6'h38
// buffer control vector: {hyst, capBypass, seSelect, seTerm, diffTerm, weakBias}
`define DRS_BUF_BIAS        0
`define DRS_BUF_DIFFTERM    1
`define DRS_BUF_SETERM      2
`define DRS_BUF_SESEL       3
`define DRS_BUF_BYPASS      4
`define DRS_BUF_HYST        5
`define DRS_BUF_OFF         6'h00

// =====================================================================
// axi responses
// =====================================================================
`define DRS_RESP_OKAY       2'h0
`define DRS_RESP_SLVERR     2'h2

`endif

// *** design/drs_valid_timer.v ***
`timescale 1ns/1ps
`include "drs_map.vh"

module drs_valid_timer (
  input  wire                     core_clk,
  input  wire                     rst_n,
  input  wire                     monitorFlag,
  input  wire [`DRS_VTIMER_W-1:0] clearCycles,
  output reg                      valid_q
);

  reg                     flagMeta_q;
  reg                     flagSync_q;
  reg [`DRS_VTIMER_W-1:0] clean_q;

  // =====================================================================
  // two-stage synchroniser: flags come from monitors off this clock
  // =====================================================================
  always @(posedge core_clk) begin
    if (!rst_n) begin
      flagMeta_q <= 1'b1;
      flagSync_q <= 1'b1;
    end else begin
      flagMeta_q <= monitorFlag;
      flagSync_q <= flagMeta_q;
    end
  end

  // =====================================================================
  // qualification: any flag restarts the clean count and drops valid
  // =====================================================================
  always @(posedge core_clk) begin
    if (!rst_n) begin
      clean_q <= {`DRS_VTIMER_W{1'b0}};
      valid_q <= 1'b0;
    end else if (flagSync_q) begin
      clean_q <= {`DRS_VTIMER_W{1'b0}};
      valid_q <= 1'b0;
    end else if (clean_q >= clearCycles) begin
      valid_q <= 1'b1;
    end else begin
      clean_q <= clean_q + 1'b1;        // saturates at the programmed time
    end
  end

endmodule // drs_valid_timer

// *** design/drs_ref_selector.v ***
`timescale 1ns/1ps
`include "drs_map.vh"

module drs_ref_selector (
  input  wire        core_clk,
  input  wire        rst_n,
  // axi4-lite slave
  input  wire [8:0]  s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [8:0]  s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // monitors and loop
  input  wire        refFlagZero,
  input  wire        refFlagOne,
  input  wire        historyValid,
  input  wire        manualSelectPin,
  // selection results
  output reg         activeRef_q,
  output reg         statusPin_q,
  output reg         tracking_q,
  output reg         holdover_q,
  output reg         freeRun_q,
  // buffer controls
  output reg  [5:0]  bufCtrlZero_q,
  output reg  [5:0]  bufCtrlOne_q,
  output reg         ampDetOkZero_q,
  output reg         ampDetOkOne_q
);

  localparam [2:0] ST_FREE  = 3'b001;
  localparam [2:0] ST_HOLD  = 3'b010;
  localparam [2:0] ST_TRACK = 3'b100;

  reg  [31:0] ctrl_q;
  reg  [31:0] vtimer_q;
  reg  [31:0] bufCfgA_q;
  reg  [31:0] bufCfgB_q;
  reg         awHeld_q;
  reg  [8:0]  awAddr_q;
  reg         wHeld_q;
  reg  [31:0] wData_q;
  reg  [3:0]  wStrb_q;
  reg         pinMeta_q;
  reg         pinSync_q;
  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg         sel_d;
  reg  [31:0] rdData;
  reg         rdHit;
  reg         wrHit;
  wire [31:0] strbMask;
  wire        doWrite;
  wire [6:0]  wrIdx;
  wire [6:0]  rdIdx;
  wire        validZero;
  wire        validOne;
  wire [1:0]  mode;
  wire [2:0]  prioZero;
  wire [2:0]  prioOne;
  wire        manChoice;
  wire        candZero;
  wire        candOne;
  wire        anyCand;
  wire        bestRef;
  wire        manValid;
  wire        curValid;
  wire [2:0]  fallState;
  wire [5:0]  decZero;
  wire [5:0]  decOne;

  // =====================================================================
  // buffer type decode
  // =====================================================================
  // unlisted codes leave every switch open so a bad code cannot load the pin
  function [5:0] decodeType;
    input [5:0] code;
    begin
      case (code)
        `DRS_CODE_00: decodeType = `DRS_CODE_00;
        `DRS_CODE_01: decodeType = `DRS_CODE_01;
        `DRS_CODE_02: decodeType = `DRS_CODE_02;
        `DRS_CODE_03: decodeType = `DRS_CODE_03;
        `DRS_CODE_04: decodeType = `DRS_CODE_04;
        `DRS_CODE_05: decodeType = `DRS_CODE_05;
        `DRS_CODE_08: decodeType = `DRS_CODE_08;
        `DRS_CODE_0C: decodeType = `DRS_CODE_0C;
        `DRS_CODE_18: decodeType = `DRS_CODE_18;
        `DRS_CODE_28: decodeType = `DRS_CODE_28;
        `DRS_CODE_38: decodeType = `DRS_CODE_38;
        default:      decodeType = `DRS_BUF_OFF;
      endcase
    end
  endfunction

  // =====================================================================
  // input qualification, one timer per input
  // =====================================================================
  drs_valid_timer uValidZero (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .monitorFlag (refFlagZero),
    .clearCycles (vtimer_q[`DRS_VTIMER_W-1:0]),
    .valid_q     (validZero)
  );

  drs_valid_timer uValidOne (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .monitorFlag (refFlagOne),
    .clearCycles (vtimer_q[`DRS_VTIMER_W-1:0]),
    .valid_q     (validOne)
  );

  // =====================================================================
  // manual select pin synchroniser
  // =====================================================================
  always @(posedge core_clk) begin
    if (!rst_n) begin
      pinMeta_q <= 1'b0;
      pinSync_q <= 1'b0;
    end else begin
      pinMeta_q <= manualSelectPin;
      pinSync_q <= pinMeta_q;
    end
  end

  // =====================================================================
  // control fields and candidate ranking
  // =====================================================================
  assign mode      = ctrl_q[`DRS_CTRL_MODE_MSB:`DRS_CTRL_MODE_LSB];
  assign prioZero  = ctrl_q[`DRS_CTRL_PRIO0_MSB:`DRS_CTRL_PRIO0_LSB];
  assign prioOne   = ctrl_q[`DRS_CTRL_PRIO1_MSB:`DRS_CTRL_PRIO1_LSB];
  assign manChoice = ctrl_q[`DRS_CTRL_PINSEL] ? pinSync_q
                                              : ctrl_q[`DRS_CTRL_MANSEL];
  assign candZero  = validZero & (prioZero != `DRS_PRIO_NEVER);
  assign candOne   = validOne & (prioOne != `DRS_PRIO_NEVER);
  assign anyCand   = candZero | candOne;
  // smaller value is better; tie goes to input zero
  assign bestRef   = candOne & ~(candZero & (prioZero <= prioOne));
  assign manValid  = manChoice ? validOne : validZero;
  assign curValid  = activeRef_q ? candOne : candZero;
  // with nothing to track, history decides between holdover and free-run
  assign fallState = historyValid ? ST_HOLD : ST_FREE;

  // =====================================================================
  // selection state machine, next state
  // =====================================================================
  always @* begin
    state_d = fallState;
    sel_d   = activeRef_q; // the mux keeps its last input while not tracking
    case (mode)
      `DRS_MODE_REVERT: begin
        if (anyCand) begin
          state_d = ST_TRACK;
          sel_d   = bestRef;
        end else begin
          state_d = fallState;
        end
      end
      `DRS_MODE_NONREVERT: begin
        if ((state_q == ST_TRACK) && curValid) begin
          state_d = ST_TRACK;
        end else if (anyCand) begin
          state_d = ST_TRACK;
          sel_d   = bestRef;
        end else begin
          state_d = fallState;
        end
      end
      `DRS_MODE_MAN_FALL: begin
        if (manValid) begin
          state_d = ST_TRACK;
          sel_d   = manChoice;
        end else if (anyCand) begin
          state_d = ST_TRACK;
          sel_d   = bestRef;
        end else begin
          state_d = fallState;
        end
      end
      `DRS_MODE_MAN_HOLD: begin
        if (manValid) begin
          state_d = ST_TRACK;
          sel_d   = manChoice;
        end else begin
          state_d = fallState;
        end
      end
      default: begin
        state_d = fallState;
      end
    endcase
  end

  // =====================================================================
  // selection registers and status outputs
  // =====================================================================
  always @(posedge core_clk) begin
    if (!rst_n) begin
      state_q     <= ST_FREE;
      activeRef_q <= 1'b0;
      statusPin_q <= 1'b0;
      tracking_q  <= 1'b0;
      holdover_q  <= 1'b0;
      freeRun_q   <= 1'b1;
    end else begin
      state_q     <= state_d;
      activeRef_q <= sel_d;
      statusPin_q <= sel_d;
      tracking_q  <= (state_d == ST_TRACK);
      holdover_q  <= (state_d == ST_HOLD);
      freeRun_q   <= (state_d == ST_FREE);
    end
  end

  // =====================================================================
  // buffer control outputs
  // =====================================================================
  assign decZero = decodeType(bufCfgA_q[`DRS_CODE_W-1:0]);
  assign decOne  = decodeType(bufCfgB_q[`DRS_CODE_W-1:0]);

  always @(posedge core_clk) begin
    if (!rst_n) begin
      bufCtrlZero_q  <= `DRS_BUF_OFF;
      bufCtrlOne_q   <= `DRS_BUF_OFF;
      ampDetOkZero_q <= 1'b0;
      ampDetOkOne_q  <= 1'b0;
    end else begin
      bufCtrlZero_q  <= decZero;
      bufCtrlOne_q   <= decOne;
      ampDetOkZero_q <= ~decZero[`DRS_BUF_BYPASS] & ~decZero[`DRS_BUF_SESEL];
      ampDetOkOne_q  <= ~decOne[`DRS_BUF_BYPASS] & ~decOne[`DRS_BUF_SESEL];
    end
  end

  // =====================================================================
  // axi4-lite write path
  // =====================================================================
  // address and data are parked independently so either may come first
  assign doWrite  = awHeld_q & wHeld_q & ~s_axi_bvalid;
  assign wrIdx    = awAddr_q[`DRS_IDX_MSB:`DRS_IDX_LSB];
  assign strbMask = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}}, {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};

  always @* begin
    case (wrIdx)
      `DRS_IDX_CTRL,
      `DRS_IDX_VTIMER,
      `DRS_IDX_BUFCFG_A,
      `DRS_IDX_BUFCFG_B: wrHit = 1'b1;
      default:           wrHit = 1'b0;
    endcase
  end

  always @(posedge core_clk) begin
    if (!rst_n) begin
      awHeld_q      <= 1'b0;
      awAddr_q      <= 9'h000;
      wHeld_q       <= 1'b0;
      wData_q       <= 32'h0000_0000;
      wStrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `DRS_RESP_OKAY;
      ctrl_q        <= `DRS_CTRL_RESET;
      vtimer_q      <= `DRS_VTIMER_RESET;
      bufCfgA_q     <= `DRS_BUFCFG_RESET;
      bufCfgB_q     <= `DRS_BUFCFG_RESET;
    end else begin
      s_axi_awready <= ~awHeld_q & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~wHeld_q & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_q     <= 1'b0;
        wHeld_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrHit ? `DRS_RESP_OKAY : `DRS_RESP_SLVERR;
        case (wrIdx)
          `DRS_IDX_CTRL:
            ctrl_q <= (ctrl_q & ~(strbMask & `DRS_CTRL_WMASK)) |
                      (wData_q & strbMask & `DRS_CTRL_WMASK);
          `DRS_IDX_VTIMER:
            vtimer_q <= (vtimer_q & ~(strbMask & `DRS_VTIMER_WMASK)) |
                        (wData_q & strbMask & `DRS_VTIMER_WMASK);
          `DRS_IDX_BUFCFG_A:
            bufCfgA_q <= (bufCfgA_q & ~(strbMask & `DRS_BUFCFG_WMASK)) |
                         (wData_q & strbMask & `DRS_BUFCFG_WMASK);
          `DRS_IDX_BUFCFG_B:
            bufCfgB_q <= (bufCfgB_q & ~(strbMask & `DRS_BUFCFG_WMASK)) |
                         (wData_q & strbMask & `DRS_BUFCFG_WMASK);
          default: begin
            ctrl_q <= ctrl_q; // unmapped or read-only: nothing stored
          end
        endcase
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // =====================================================================
  // axi4-lite read path
  // =====================================================================
  assign rdIdx = s_axi_araddr[`DRS_IDX_MSB:`DRS_IDX_LSB];

  always @* begin
    rdHit  = 1'b1;
    rdData = 32'h0000_0000;
    case (rdIdx)
      `DRS_IDX_CTRL:     rdData = ctrl_q;
      `DRS_IDX_VTIMER:   rdData = vtimer_q;
      `DRS_IDX_STATUS:   rdData = {25'h0, validOne, validZero, freeRun_q, holdover_q,
                                   tracking_q, 1'b0, activeRef_q};
      `DRS_IDX_BUFCFG_A: rdData = bufCfgA_q;
      `DRS_IDX_BUFCFG_B: rdData = bufCfgB_q;
      `DRS_IDX_BUFSTAT:  rdData = {16'h0, 1'b0, ampDetOkOne_q, bufCtrlOne_q,
                                   1'b0, ampDetOkZero_q, bufCtrlZero_q};
      default:           rdHit  = 1'b0;
    endcase
  end

  // one read at a time: arready drops while the data beat waits
  always @(posedge core_clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `DRS_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdData;
        s_axi_rresp  <= rdHit ? `DRS_RESP_OKAY : `DRS_RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // drs_ref_selector

// *** bench/drs_sel_checker.sv ***
`timescale 1ns/1ps
// =====================================================================
// selector port checker
// =====================================================================
module drs_sel_checker (
  input wire        core_clk,
  input wire        rst_n,
  input wire        s_axi_awready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire        historyValid,
  input wire        activeRef_q,
  input wire        statusPin_q,
  input wire        tracking_q,
  input wire        holdover_q,
  input wire        freeRun_q,
  input wire [5:0]  bufCtrlZero_q,
  input wire [5:0]  bufCtrlOne_q,
  input wire        ampDetOkZero_q,
  input wire        ampDetOkOne_q
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // the pin copy must never lag the chosen input
  chk_pin_mirror: assert property (statusPin_q == activeRef_q)
    else $error("status pin differs from active input");
  chk_state_onehot: assert property ($onehot({tracking_q, holdover_q, freeRun_q}))
    else $error("selector state not one-hot");
  // history decides between holdover and free-run at the entering edge
  chk_hold_entry: assert property ($rose(holdover_q) |-> $past(historyValid))
    else $error("holdover entered without history");
  chk_free_entry: assert property ($rose(freeRun_q) |-> !$past(historyValid))
    else $error("free-run entered with history");
  // settled buffer controls out of reset only: the detector flag resets low
  chk_amp_zero: assert property ($past(rst_n) && $stable(bufCtrlZero_q)
    ##1 $stable(bufCtrlZero_q)
    |-> ampDetOkZero_q == !(bufCtrlZero_q[4] | bufCtrlZero_q[3]))
    else $error("input zero amplitude detector flag wrong");
  chk_amp_one: assert property ($past(rst_n) && $stable(bufCtrlOne_q)
    ##1 $stable(bufCtrlOne_q)
    |-> ampDetOkOne_q == !(bufCtrlOne_q[4] | bufCtrlOne_q[3]))
    else $error("input one amplitude detector flag wrong");
  // bus handshakes
  chk_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  chk_ready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("write address ready longer than one cycle");
endmodule // drs_sel_checker

bind drs_ref_selector drs_sel_checker drs_sel_checker_i (.core_clk, .rst_n, .s_axi_awready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .historyValid,
  .activeRef_q, .statusPin_q, .tracking_q, .holdover_q, .freeRun_q, .bufCtrlZero_q,
  .bufCtrlOne_q, .ampDetOkZero_q, .ampDetOkOne_q);

// *** bench/drs_ref_source.sv ***
`timescale 1ns/1ps
// =====================================================================
// reference sources and loop history
// =====================================================================
module drs_ref_source (
  input  wire       core_clk,
  input  wire [1:0] faultReq,
  input  wire       histReq,
  input  wire       pinReq,
  output reg        refFlagZero     = 1'b1,
  output reg        refFlagOne      = 1'b1,
  output reg        historyValid    = 1'b0,
  output reg        manualSelectPin = 1'b0
);
  // flags start raised so nothing looks valid before the timers ran
  always @(posedge core_clk) begin
    refFlagZero     <= faultReq[0];
    refFlagOne      <= faultReq[1];
    historyValid    <= histReq;
    manualSelectPin <= pinReq;
  end
endmodule // drs_ref_source

// *** bench/drs_ref_selector_bench.sv ***
`timescale 1ns/1ps
`include "drs_map.vh"
module drs_ref_selector_bench;
  // =====================================================================
  // signals
  // =====================================================================
  logic        core_clk = 0, rst_n = 0;
  logic [8:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  wire  [31:0] s_axi_rdata;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire         refFlagZero, refFlagOne, historyValid, manualSelectPin;
  wire         activeRef_q, statusPin_q, tracking_q, holdover_q, freeRun_q;
  wire         ampDetOkZero_q, ampDetOkOne_q;
  wire  [5:0]  bufCtrlZero_q, bufCtrlOne_q;
  logic [1:0]  faultReq = 2'h3;
  logic        histReq = 0, pinReq = 0;
  integer      mismatches = 0, nChecks = 0, cycles = 0, i;
  // type codes and the controls they must give; 0x3f is unlisted
  logic [5:0]  tc [8] = '{6'h05, 6'h08, 6'h0c, 6'h18, 6'h28, 6'h38, 6'h3f, 6'h00};
  logic [5:0]  tx [8] = '{6'h05, 6'h08, 6'h0c, 6'h18, 6'h28, 6'h38, 6'h00, 6'h00};

  drs_ref_selector drs_ref_selector_i (.core_clk, .rst_n, .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .refFlagZero, .refFlagOne, .historyValid, .manualSelectPin,
    .activeRef_q, .statusPin_q, .tracking_q, .holdover_q, .freeRun_q, .bufCtrlZero_q,
    .bufCtrlOne_q, .ampDetOkZero_q, .ampDetOkOne_q);
  drs_ref_source drs_ref_source_i (.core_clk, .faultReq, .histReq, .pinReq, .refFlagZero,
    .refFlagOne, .historyValid, .manualSelectPin);

  // =====================================================================
  // helpers
  // =====================================================================
  function [8:0] ad(input [6:0] x);
    ad = {x, 2'b00};
  endfunction
  function [31:0] ctl(input [1:0] m, input s, input p, input [2:0] a, input [2:0] b);
    ctl = {21'h0, b, 1'b0, a, p, s, m};
  endfunction
  function [6:0] bs(input [5:0] c);
    bs = {~(c[4] | c[3]), c};
  endfunction
  task chk(input [31:0] g, input [31:0] e);
    begin
      nChecks++;
      if (g !== e) begin
        mismatches++;
        $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  // master holds each valid until its own ready edge
  task wr(input [8:0] a, input [31:0] d, input [1:0] er);
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
        @(posedge core_clk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      chk({30'h0, s_axi_bresp}, {30'h0, er});
      s_axi_bready <= 1'b0;
      @(posedge core_clk);
    end
  endtask
  // rready comes late on purpose so read data must stand
  task rd(input [8:0] a, output [31:0] d, output [1:0] r);
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
        @(posedge core_clk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b1;
      @(posedge core_clk);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge core_clk);
    end
  endtask
  task rc(input [8:0] a, input [31:0] e, input [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    begin
      rd(a, d, r);
      chk(d, e);
      chk({30'h0, r}, {30'h0, er});
    end
  endtask
  // poll status until it settles, bounded since revalidation takes a while
  task ws(input [6:0] m, input [6:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    integer      k;
    begin
      k = 0;
      do begin
        rd(ad(`DRS_IDX_STATUS), d, r);
        k++;
      end while ((d[6:0] & m) !== e && k < 60);
      chk({25'h0, d[6:0] & m}, {25'h0, e});
    end
  endtask
  task finishTest;
    begin
      if (mismatches == 0 && nChecks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask

  // =====================================================================
  // clock, watchdog, sequence
  // =====================================================================
  initial forever #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      finishTest();
    end
  end
  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rc(ad(`DRS_IDX_CTRL), `DRS_CTRL_RESET, `DRS_RESP_OKAY);
    rc(ad(`DRS_IDX_VTIMER), `DRS_VTIMER_RESET, `DRS_RESP_OKAY);
    rc(ad(`DRS_IDX_STATUS), 32'h10, `DRS_RESP_OKAY);
    rc(9'h0fc, 32'h0, `DRS_RESP_SLVERR);
    wr(9'h0fc, 32'h1, `DRS_RESP_SLVERR);
    wr(ad(`DRS_IDX_STATUS), 32'h1, `DRS_RESP_SLVERR);
    wr(ad(`DRS_IDX_VTIMER), 32'h4, `DRS_RESP_OKAY);
    // the two inputs get different codes so a swap shows
    for (i = 0; i < 8; i++) begin
      wr(ad(`DRS_IDX_BUFCFG_A), {26'h0, tc[i]}, `DRS_RESP_OKAY);
      wr(ad(`DRS_IDX_BUFCFG_B), {26'h0, tc[7 - i]}, `DRS_RESP_OKAY);
      rc(ad(`DRS_IDX_BUFSTAT), {17'h0, bs(tx[7 - i]), 1'b0, bs(tx[i])}, 0);
      chk({26'h0, bufCtrlZero_q}, {26'h0, tx[i]});
    end
    faultReq <= 2'h0;
    ws(7'h7f, 7'h70);
    histReq <= 1'b1;
    ws(7'h7f, 7'h68);
    wr(ad(`DRS_IDX_CTRL), ctl(`DRS_MODE_REVERT, 0, 0, 2, 1), 0);
    ws(7'h7f, 7'h65);
    wr(ad(`DRS_IDX_CTRL), ctl(`DRS_MODE_REVERT, 0, 0, 3, 3), 0);
    ws(7'h7f, 7'h64);
    wr(ad(`DRS_IDX_CTRL), ctl(`DRS_MODE_REVERT, 0, 0, 1, 2), 0);
    faultReq <= 2'h1;
    ws(7'h7f, 7'h45);
    faultReq <= 2'h0;
    ws(7'h7f, 7'h64);
    wr(ad(`DRS_IDX_CTRL), ctl(`DRS_MODE_NONREVERT, 0, 0, 1, 2), 0);
    faultReq <= 2'h1;
    ws(7'h7f, 7'h45);
    faultReq <= 2'h0;
    ws(7'h20, 7'h20);
    ws(7'h7f, 7'h65);
    histReq <= 1'b0;
    faultReq <= 2'h3;
    ws(7'h7e, 7'h10);
    histReq <= 1'b1;
    faultReq <= 2'h0;
    wr(ad(`DRS_IDX_CTRL), ctl(`DRS_MODE_MAN_FALL, 1, 0, 1, 1), 0);
    ws(7'h7f, 7'h65);
    faultReq <= 2'h2;
    ws(7'h7f, 7'h24);
    faultReq <= 2'h3;
    ws(7'h7e, 7'h08);
    faultReq <= 2'h1;
    ws(7'h7f, 7'h45);
    faultReq <= 2'h0;
    wr(ad(`DRS_IDX_CTRL), ctl(`DRS_MODE_MAN_HOLD, 0, 1, 0, 1), 0);
    ws(7'h7f, 7'h64);
    faultReq <= 2'h1;
    ws(7'h7e, 7'h48);
    faultReq <= 2'h0;
    ws(7'h7f, 7'h64);
    pinReq <= 1'b1;
    ws(7'h7f, 7'h65);
    chk({31'h0, activeRef_q}, 32'h1);
    chk({31'h0, statusPin_q}, 32'h1);
    finishTest();
  end
endmodule // drs_ref_selector_bench
